//--- rtl/pwr_params.svh
// Reset values and encodings for the power-down wake controller
`ifndef PWR_PARAMS_SVH
`define PWR_PARAMS_SVH
`define PWR_SP_INIT 3'h7
`define PWR_PC_INIT 16'h0000
`define PWR_CNT_IN_SEL 2'h3
`endif

//--- rtl/pwr_pkg.sv
// Types for the power-down wake controller
`default_nettype none
package pwr_pkg;
  typedef enum logic [1:0] {
    st_run,
    st_clock_mode,
    st_ram_backup
  } mode_t;
endpackage : pwr_pkg
`default_nettype wire

//--- rtl/power_down_wake_control.sv
// Power-down entry, wake and warm/cold start control
`include "pwr_params.svh"
`default_nettype none
module power_down_wake_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction strobes from the decoder
  input wire logic enable_power_down_instr,
  input wire logic clock_mode_entry_instr,
  input wire logic ram_backup_entry_instr,
  input wire logic supply_detect_hold_instr,
  input wire logic skip_if_power_flag_instr,
  // Reset sources and wake events
  input wire logic reset_pin,
  input wire logic watchdog_reset,
  input wire logic drop_reset,
  input wire logic ext_wakeup,
  input wire logic timer5_underflow,
  input wire logic timer5_request_flag,
  input wire logic drop_detect_enable_pin,
  // Counter pin selection
  input wire logic counter_select_hi,
  input wire logic counter_select_lo,
  input wire logic counter_out_level,
  // Status and control outputs
  output logic power_flag,
  output logic skip_next,
  output logic powered_down,
  output logic ram_backup_active,
  output logic osc_stop,
  output logic timer5_run,
  output logic display_on,
  output logic drop_detect_active,
  output logic restart,
  output logic [15:0] restart_pc,
  output logic [2:0] stack_pointer,
  output logic cpu_regs_init,
  output logic flags_clear,
  output logic watchdog_init,
  output logic warm_clock_start,
  output logic counter_io_pin_o,
  output logic counter_io_pin_oe_n
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] p1;
    logic [4:0] p2;
    pwr_pkg::mode_t mode;
    logic armed;
    logic hold;
    logic pflag;
    logic skip;
    logic restart;
    logic [15:0] pc;
    logic [2:0] sp;
    logic init;
    logic warm5;
    logic drop_act;
    logic cnt_o;
    logic cnt_oe_n;
    logic down;
    logic backup;
    logic osc;
    logic t5run;
    logic disp;
  } st_t;
  st_t q, d;
  // Pins pass two flops; vector 0 ext,1 drop pin,2 reset,3 sel hi,4 sel lo
  logic [4:0] pin_s;
  logic entry;
  logic wake;
  logic cold;
  logic cnt_in;
  assign pin_s = q.p2;
  assign cold = pin_s[2] | watchdog_reset | drop_reset;
  assign cnt_in = {pin_s[3], pin_s[4]} == `PWR_CNT_IN_SEL;
  assign entry = q.armed & (clock_mode_entry_instr | ram_backup_entry_instr);
  // Clock mode sees wake or timer 5; backup only wake, oscillator is stopped
  assign wake = (q.mode == pwr_pkg::st_clock_mode) ?
                (pin_s[0] | timer5_underflow | timer5_request_flag) :
                pin_s[0];
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.p1 = {counter_select_lo, counter_select_hi, reset_pin,
            drop_detect_enable_pin, ext_wakeup};
    d.p2 = q.p1;
    d.restart = 1'b0;
    d.init = 1'b0;
    d.skip = skip_if_power_flag_instr & q.pflag;
    // Hold instruction is one-shot until the next reset
    if (supply_detect_hold_instr) begin
      d.hold = 1'b1;
    end
    case (q.mode)
      pwr_pkg::st_run: begin
        if (enable_power_down_instr) begin
          d.armed = 1'b1;
        end
        if (entry) begin
          d.armed = 1'b0;
          d.mode = clock_mode_entry_instr ? pwr_pkg::st_clock_mode :
                   pwr_pkg::st_ram_backup;
          d.init = 1'b1;
          d.pc = `PWR_PC_INIT;
          d.sp = `PWR_SP_INIT;
          // Control registers, oscillator choice and the timer 5 flag
          // live outside and are never touched here
          // Timers 1 to 4 get no init; software must not trust them
        end else if (clock_mode_entry_instr | ram_backup_entry_instr) begin
          d.armed = 1'b0;
        end
      end
      pwr_pkg::st_clock_mode, pwr_pkg::st_ram_backup: begin
        if (wake) begin
          d.mode = pwr_pkg::st_run;
          d.pflag = 1'b1;
          d.restart = 1'b1;
          d.pc = `PWR_PC_INIT;
          d.warm5 = (q.mode == pwr_pkg::st_clock_mode) &
                    timer5_request_flag;
        end
      end
      default: d.mode = pwr_pkg::st_run;
    endcase
    // Cold start overrides mode, power flag, enable, hold, restart, pc and warm start; memory stays untouched here
    // It goes after the mode case so pin and status flops follow the final mode
    if (cold) begin
      d.mode = pwr_pkg::st_run;
      d.pflag = 1'b0;
      d.armed = 1'b0;
      d.hold = 1'b0;
      d.restart = 1'b1;
      d.pc = `PWR_PC_INIT;
      d.warm5 = 1'b0;
    end
    d.drop_act = (d.mode == pwr_pkg::st_run) ? pin_s[1] :
                 (pin_s[1] & d.hold);
    // Counter pin: input if selected, else driven low while down
    if (d.mode != pwr_pkg::st_run) begin
      d.cnt_o = 1'b0;
      d.cnt_oe_n = cnt_in;
    end else begin
      d.cnt_o = counter_out_level;
      d.cnt_oe_n = 1'b0;
    end
    // Status outputs come from flops, decoded from the next mode
    d.down = d.mode != pwr_pkg::st_run;
    d.backup = d.mode == pwr_pkg::st_ram_backup;
    d.osc = d.backup;
    d.t5run = !d.backup;
    d.disp = !d.backup;
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.sp <= `PWR_SP_INIT;
      q.t5run <= 1'b1;
      q.disp <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // Outputs straight from flops
  assign power_flag = q.pflag;
  assign skip_next = q.skip;
  assign powered_down = q.down;
  assign ram_backup_active = q.backup;
  assign osc_stop = q.osc;
  assign timer5_run = q.t5run;
  assign display_on = q.disp;
  assign drop_detect_active = q.drop_act;
  assign restart = q.restart;
  assign restart_pc = q.pc;
  assign stack_pointer = q.sp;
  assign cpu_regs_init = q.init;
  assign flags_clear = q.init;
  assign watchdog_init = q.init;
  assign warm_clock_start = q.warm5;
  assign counter_io_pin_o = q.cnt_o;
  assign counter_io_pin_oe_n = q.cnt_oe_n;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_noop_entry;
    @(posedge clk) disable iff (rst)
      (!q.armed && !powered_down && clock_mode_entry_instr && !cold) |=>
      !powered_down;
  endproperty
  a_noop_entry: assert property (p_noop_entry)
    else $error("entry without enable changed mode");
  property p_entry;
    @(posedge clk) disable iff (rst)
      (entry && !cold) |=> (powered_down && cpu_regs_init &&
      stack_pointer == 3'h7);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry did not init state");
  property p_warm;
    @(posedge clk) disable iff (rst)
      (powered_down && wake && !cold) |=> (power_flag && restart &&
      restart_pc == 16'h0000);
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm start wrong");
  property p_cold;
    @(posedge clk) disable iff (rst)
      cold |=> (!power_flag && restart && !powered_down);
  endproperty
  a_cold: assert property (p_cold)
    else $error("cold start wrong");
  property p_backup_t5;
    @(posedge clk) disable iff (rst)
      (ram_backup_active && !pin_s[0] && !cold) |=> ram_backup_active;
  endproperty
  a_backup_t5: assert property (p_backup_t5)
    else $error("backup left without wakeup");
  property p_display;
    @(posedge clk) disable iff (rst)
      display_on == (q.mode != pwr_pkg::st_ram_backup);
  endproperty
  a_display: assert property (p_display)
    else $error("display state wrong");
  property p_cnt;
    @(posedge clk) disable iff (rst)
      (powered_down && !counter_io_pin_oe_n) |-> !counter_io_pin_o;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("counter pin not low");
  property p_skip;
    @(posedge clk) disable iff (rst)
      skip_if_power_flag_instr |=> (skip_next == $past(power_flag));
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip wrong");
  property p_drop;
    @(posedge clk) disable iff (rst)
      (powered_down && !q.hold) |-> !drop_detect_active;
  endproperty
  a_drop: assert property (p_drop)
    else $error("drop detect active without hold");
  property p_clock_keep;
    @(posedge clk) disable iff (rst)
      (powered_down && !ram_backup_active) |->
      (timer5_run && display_on && !osc_stop);
  endproperty
  a_clock_keep: assert property (p_clock_keep)
    else $error("clock mode lost timer or display");
  property p_backup_state;
    @(posedge clk) disable iff (rst)
      ram_backup_active |->
      (powered_down && osc_stop && !timer5_run && !display_on);
  endproperty
  a_backup_state: assert property (p_backup_state)
    else $error("backup mode left display or oscillator on");
  property p_t5_flag;
    @(posedge clk) disable iff (rst)
      (powered_down && !ram_backup_active && timer5_request_flag && !cold)
      |=> (!powered_down && warm_clock_start);
  endproperty
  a_t5_flag: assert property (p_t5_flag)
    else $error("timer 5 flag wake not marked");
  property p_cold_disarm;
    @(posedge clk) disable iff (rst)
      cold |=>
      (!q.armed && !q.hold && !warm_clock_start);
  endproperty
  a_cold_disarm: assert property (p_cold_disarm)
    else $error("cold start left enable or hold set");
  property p_restart_pc;
    @(posedge clk) disable iff (rst)
      restart |->
      (restart_pc == `PWR_PC_INIT && !powered_down);
  endproperty
  a_restart_pc: assert property (p_restart_pc)
    else $error("restart not at page 0 address 0");
endmodule : power_down_wake_control
`default_nettype wire

//--- verification/wake_src_model.sv
// Wake pins and reset sources on the far side of the controller
`default_nettype none
module wake_src_model #(
  parameter int HOLD = 3
) (
  // Clock, reset and bench requests
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] ev,
  input wire logic pin_hi,
  // Lines into the controller
  output logic ext_wakeup,
  output logic timer5_underflow,
  output logic timer5_request_flag,
  output logic reset_pin,
  output logic watchdog_reset,
  output logic drop_reset,
  output logic drop_detect_enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  logic [2:0] ev_q;
  // Events stand HOLD cycles, long enough for the two-flop syncs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      ev_q <= 3'h0;
    end else if (ev != 3'h0) begin
      cnt_q <= HOLD;
      ev_q <= ev;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // One line per event source, idle low between events; the detect pin follows pin_hi
  assign ext_wakeup = cnt_q > 0 && ev_q == 3'h1;
  assign timer5_underflow = cnt_q > 0 && ev_q == 3'h2;
  assign timer5_request_flag = cnt_q > 0 && ev_q == 3'h3;
  assign reset_pin = cnt_q > 0 && ev_q == 3'h4;
  assign watchdog_reset = cnt_q > 0 && ev_q == 3'h5;
  assign drop_reset = cnt_q > 0 && ev_q == 3'h6;
  assign drop_detect_enable_pin = pin_hi;
endmodule : wake_src_model
`default_nettype wire

//--- verification/tb.sv
// Directed bench for the power-down wake controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] instr = 5'h0;
  logic [2:0] ev = 3'h0;
  logic pin_hi = 1'b1;
  logic counter_select_hi = 1'b0;
  logic counter_select_lo = 1'b0;
  logic counter_out_level = 1'b1;
  logic enable_power_down_instr, clock_mode_entry_instr;
  logic ram_backup_entry_instr, supply_detect_hold_instr;
  logic skip_if_power_flag_instr, ext_wakeup, timer5_underflow;
  logic timer5_request_flag, reset_pin, watchdog_reset, drop_reset;
  logic drop_detect_enable_pin, power_flag, skip_next, powered_down;
  logic ram_backup_active, osc_stop, timer5_run, display_on, restart;
  logic drop_detect_active, cpu_regs_init, flags_clear, watchdog_init;
  logic warm_clock_start, counter_io_pin_o, counter_io_pin_oe_n;
  logic [15:0] restart_pc;
  logic [2:0] stack_pointer;
  int failures = 0;
  int cmp_count = 0;
  assign {skip_if_power_flag_instr, supply_detect_hold_instr,
    ram_backup_entry_instr, clock_mode_entry_instr,
    enable_power_down_instr} = instr;
  power_down_wake_control dut_u (
    .clk(clk),
    .rst(rst),
    .enable_power_down_instr(enable_power_down_instr),
    .clock_mode_entry_instr(clock_mode_entry_instr),
    .ram_backup_entry_instr(ram_backup_entry_instr),
    .supply_detect_hold_instr(supply_detect_hold_instr),
    .skip_if_power_flag_instr(skip_if_power_flag_instr),
    .reset_pin(reset_pin),
    .watchdog_reset(watchdog_reset),
    .drop_reset(drop_reset),
    .ext_wakeup(ext_wakeup),
    .timer5_underflow(timer5_underflow),
    .timer5_request_flag(timer5_request_flag),
    .drop_detect_enable_pin(drop_detect_enable_pin),
    .counter_select_hi(counter_select_hi),
    .counter_select_lo(counter_select_lo),
    .counter_out_level(counter_out_level),
    .power_flag(power_flag),
    .skip_next(skip_next),
    .powered_down(powered_down),
    .ram_backup_active(ram_backup_active),
    .osc_stop(osc_stop),
    .timer5_run(timer5_run),
    .display_on(display_on),
    .drop_detect_active(drop_detect_active),
    .restart(restart),
    .restart_pc(restart_pc),
    .stack_pointer(stack_pointer),
    .cpu_regs_init(cpu_regs_init),
    .flags_clear(flags_clear),
    .watchdog_init(watchdog_init),
    .warm_clock_start(warm_clock_start),
    .counter_io_pin_o(counter_io_pin_o),
    .counter_io_pin_oe_n(counter_io_pin_oe_n)
  );
  wake_src_model #(.HOLD(3)) model_u (
    .clk(clk),
    .rst(rst),
    .ev(ev),
    .pin_hi(pin_hi),
    .ext_wakeup(ext_wakeup),
    .timer5_underflow(timer5_underflow),
    .timer5_request_flag(timer5_request_flag),
    .reset_pin(reset_pin),
    .watchdog_reset(watchdog_reset),
    .drop_reset(drop_reset),
    .drop_detect_enable_pin(drop_detect_enable_pin)
  );
  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] exp,
    input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Instruction strobes are one-cycle pulses, one bit of instr each
  task automatic pulse(input int idx);
    @(posedge clk);
    instr <= 5'(1 << idx);
    @(posedge clk);
    instr <= 5'h00;
    #1;
  endtask : pulse
  // Settle past the edge so the next look never races the design
  task automatic fire(input logic [2:0] code);
    @(posedge clk);
    ev <= code;
    @(posedge clk);
    ev <= 3'h0;
    #1;
  endtask : fire
  // Bounded wait; a stuck mode ends the run as a failure
  task automatic wait_pd(input logic val);
    int n;
    n = 0;
    while (powered_down !== val && n < 12) begin
      tick(1);
      n++;
    end
    if (powered_down !== val) begin
      failures++;
      final_report();
    end
  endtask : wait_pd
  // Software restarts the watchdog before entry; no pin for it here
  task automatic enter(input int idx);
    pulse(0);
    pulse(idx);
    wait_pd(1'b1);
    chk("sp", 16'h0007, stack_pointer);
    chk("regs init", 16'h0001, cpu_regs_init);
    chk("flags clear", 16'h0001, flags_clear);
    chk("wd init", 16'h0001, watchdog_init);
  endtask : enter
  task automatic wake(input logic [2:0] code, input logic warm);
    fire(code);
    wait_pd(1'b0);
    chk("restart", 16'h0001, restart);
    chk("pc", 16'h0000, restart_pc);
    chk("pflag", {15'h0000, warm}, power_flag);
    pulse(4);
    chk("skip", {15'h0000, warm}, skip_next);
    // Software rewrites undefined registers here; nothing to model
  endtask : wake
  // Main sequence: refused entry, both modes, every wake and cold source
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("pflag", 16'h0000, power_flag);
    chk("sp reset", 16'h0007, stack_pointer);
    pulse(1);
    tick(3);
    chk("no entry", 16'h0000, powered_down);
    chk("run pins", 16'h0006, {drop_detect_active, counter_io_pin_o,
      counter_io_pin_oe_n});
    // Detect pin low disables drop detection even while running
    @(posedge clk);
    pin_hi <= 1'b0;
    counter_out_level <= 1'b0;
    tick(4);
    chk("pin low", 16'h0000, {drop_detect_active, counter_io_pin_o,
      counter_io_pin_oe_n});
    @(posedge clk);
    pin_hi <= 1'b1;
    counter_out_level <= 1'b1;
    tick(4);
    enter(1);
    tick(2);
    chk("clock mode", 16'h0003, {ram_backup_active, osc_stop, timer5_run,
      display_on});
    chk("clock pins", 16'h0000, {drop_detect_active, counter_io_pin_o,
      counter_io_pin_oe_n});
    wake(3'h2, 1'b1);
    chk("uf start", 16'h0000, warm_clock_start);
    enter(1);
    wake(3'h3, 1'b1);
    chk("t5 start", 16'h0001, warm_clock_start);
    @(posedge clk);
    counter_select_hi <= 1'b1;
    counter_select_lo <= 1'b1;
    pulse(3);
    enter(2);
    tick(3);
    chk("ram mode", 16'h000C, {ram_backup_active, osc_stop, timer5_run,
      display_on});
    chk("ram pins", 16'h0005, {drop_detect_active, counter_io_pin_o,
      counter_io_pin_oe_n});
    fire(3'h2);
    tick(5);
    chk("t5 ignored", 16'h0001, powered_down);
    wake(3'h1, 1'b1);
    chk("ext start", 16'h0000, warm_clock_start);
    for (int i = 4; i <= 6; i++) begin
      enter(i == 5 ? 2 : 1);
      wake(3'(i), 1'b0);
    end
    enter(1);
    tick(3);
    chk("hold cleared", 16'h0000, drop_detect_active);
    wake(3'h1, 1'b1);
    final_report();
  end
  // Overall limit on the run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
endmodule : tb
`default_nettype wire
